// ---- src/scc_consts.svh ----
// Constants for the sampling converter control block: addresses, bit positions,
// reset values and timing counts. Assumes a 25 MHz system clock.
`ifndef SCC_CONSTS_SVH
`define SCC_CONSTS_SVH

// DSP external register slots
`define SCC_ADDR_DATA 3'h5
`define SCC_ADDR_CTRL 3'h6

// Control word bit positions
`define SCC_B_CAPRATE 0
`define SCC_B_XTAL 1
`define SCC_B_RSVZ 2
`define SCC_B_START 3
`define SCC_B_DONE 4
`define SCC_B_ADCEN 5
`define SCC_B_GPA 6
`define SCC_B_GPB 7
`define SCC_B_PLAYRATE 8
`define SCC_B_RSVONE 9
`define SCC_B_IRQSEL 15

// Reset value of the stored control fields: start bit set, all else clear
`define SCC_START_RST 1'b1

// System clock
`define SCC_CLK_HZ 25000000
`define SCC_CLK_NS 40

// Sample rates in Hz, by crystal (X20 = 20.48 MHz, X29 = 29.49 MHz) and rate bit
`define SCC_HZ_PLAY_X20_R0 16000
`define SCC_HZ_PLAY_X20_R1 10000
`define SCC_HZ_PLAY_X29_R0 8040
`define SCC_HZ_PLAY_X29_R1 9600
`define SCC_HZ_CAP_X20_R0 8000
`define SCC_HZ_CAP_X20_R1 16000
`define SCC_HZ_CAP_X29_R0 9600
`define SCC_HZ_CAP_X29_R1 16000

// Timer periods in system clock cycles
`define SCC_CYC(hz) (12'(`SCC_CLK_HZ / (hz)))

// Longest conversion time, rounded down to whole cycles
`define SCC_CONV_NS 2000
`define SCC_CONV_CYC (6'(`SCC_CONV_NS / `SCC_CLK_NS))

// PWM slot count per active region and slots per group
`define SCC_PWM_SLOTS 13'h0400
`define SCC_PWM_GROUP 32

`endif

// ---- src/scc_pkg.sv ----
// Types shared by the sampling converter control block.
// Assumes the DSP external register port presents one request per cycle.
package scc_pkg;

  // One access from the DSP core to an external register slot
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [15:0] wdata;
  } sccExtReq_t;

  // Stored writable fields of the analog control word
  typedef struct packed {
    logic irqSel;
    logic playRate;
    logic gpB;
    logic gpA;
    logic adcEn;
    logic startBit;
    logic xtalSel;
    logic capRate;
  } sccCtrl_t;

  typedef enum logic {SCC_IDLE, SCC_CONV} sccConvState_t;

endpackage : scc_pkg

// ---- src/scc_buffer.sv ----
// Small FIFO with valid/ready on both sides, used for playback samples.
// Assumes one clock and a synchronous active-low reset.
module scc_buffer #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wrPtr_q;
  logic [PW-1:0] rdPtr_q;
  logic [CW-1:0] count_q;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count
  assign inReady = (count_q != CW'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData = mem_q[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // Storage; not reset since data is only read when valid
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  // Pointers wrap at the depth
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == PW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == PW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
      end
    end
  end

  // Occupancy; simultaneous push and pop leave it unchanged
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      count_q <= '0;
    end else if (push && !pop) begin
      count_q <= count_q + 1'b1;
    end else if (pop && !push) begin
      count_q <= count_q - 1'b1;
    end
  end

endmodule : scc_buffer

// ---- src/scc_top.sv ----
// Converter control: analog control word, capture and playback pacing timers,
// A/D start/done handshake, two general outputs and the 10-bit PWM modulator.
// Assumes the DSP core is the only master and the A/D result is a static input.
`include "scc_consts.svh"

module scc_top (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire scc_pkg::sccExtReq_t extReq,
  output logic [15:0] extRdData,
  output logic extRdValid,
  input wire logic [7:0] adcSample,
  input wire logic externalPortPin,
  output logic gpOutputA,
  output logic gpOutputB,
  output logic adcPowerOn,
  output logic adcConvBusy,
  output logic captureIrq,
  output logic adDoneIrq,
  output logic playbackIrq,
  output logic lowestDspIrqLine,
  output logic pwmOut,
  output logic dacWriteReady
);

  scc_pkg::sccCtrl_t ctrl_q;
  scc_pkg::sccConvState_t convState_q;
  logic doneFlag_q;
  logic [7:0] adcResult_q;
  logic [5:0] convCnt_q;
  logic capRateAct_q;
  logic xtalAct_q;
  logic [11:0] capCnt_q;
  logic [11:0] playCnt_q;
  logic [11:0] capPeriod;
  logic [11:0] playPeriod;
  logic [11:0] activeLen;
  logic [14:0] activeMul;
  logic capTick;
  logic playTick;
  logic ctrlWr;
  logic dataWr;
  logic dataRd;
  logic startCmd;
  logic convFinish;
  logic [9:0] pwmSample_q;
  logic [9:0] slot_q;
  logic [11:0] acc_q;
  logic [12:0] accSum;
  logic inActive;
  logic slotHigh;
  logic bufInReady;
  logic bufOutValid;
  logic [9:0] bufOutData;

  // Pick one of four cycle counts by crystal and rate bit
  function automatic logic [11:0] pickCount(input logic xtal, input logic rate,
      input logic [11:0] x20r0, input logic [11:0] x20r1,
      input logic [11:0] x29r0, input logic [11:0] x29r1);
    logic [11:0] r;
    r = xtal ? (rate ? x29r1 : x29r0) : (rate ? x20r1 : x20r0);
    return r;
  endfunction : pickCount

  // Register port decode; only slots five and six are mapped
  assign ctrlWr = extReq.wr && (extReq.addr == `SCC_ADDR_CTRL);
  assign dataWr = extReq.wr && (extReq.addr == `SCC_ADDR_DATA);
  assign dataRd = extReq.rd && (extReq.addr == `SCC_ADDR_DATA);
  assign startCmd = ctrlWr && extReq.wdata[`SCC_B_START];

  // reserved bits are simply not stored
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ctrl_q <= '0;
      ctrl_q.startBit <= `SCC_START_RST;
    end else if (ctrlWr) begin
      ctrl_q.irqSel <= extReq.wdata[`SCC_B_IRQSEL];
      ctrl_q.playRate <= extReq.wdata[`SCC_B_PLAYRATE];
      ctrl_q.gpB <= extReq.wdata[`SCC_B_GPB];
      ctrl_q.gpA <= extReq.wdata[`SCC_B_GPA];
      ctrl_q.adcEn <= extReq.wdata[`SCC_B_ADCEN];
      ctrl_q.startBit <= extReq.wdata[`SCC_B_START];
      ctrl_q.xtalSel <= extReq.wdata[`SCC_B_XTAL];
      ctrl_q.capRate <= extReq.wdata[`SCC_B_CAPRATE];
    end
  end

  // capture settings are taken over only on a start command
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      capRateAct_q <= 1'b0;
      xtalAct_q <= 1'b0;
    end else if (startCmd) begin
      capRateAct_q <= extReq.wdata[`SCC_B_CAPRATE];
      xtalAct_q <= extReq.wdata[`SCC_B_XTAL];
    end
  end

  assign capPeriod = pickCount(xtalAct_q, capRateAct_q,
      `SCC_CYC(`SCC_HZ_CAP_X20_R0), `SCC_CYC(`SCC_HZ_CAP_X20_R1),
      `SCC_CYC(`SCC_HZ_CAP_X29_R0), `SCC_CYC(`SCC_HZ_CAP_X29_R1));
  assign playPeriod = pickCount(ctrl_q.xtalSel, ctrl_q.playRate,
      `SCC_CYC(`SCC_HZ_PLAY_X20_R0), `SCC_CYC(`SCC_HZ_PLAY_X20_R1),
      `SCC_CYC(`SCC_HZ_PLAY_X29_R0), `SCC_CYC(`SCC_HZ_PLAY_X29_R1));

  assign capTick = (capCnt_q >= capPeriod - 12'h001);
  assign playTick = (playCnt_q >= playPeriod - 12'h001);

  // free running capture timer; >= guards against a shortened period
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      capCnt_q <= '0;
    end else if (capTick) begin
      capCnt_q <= '0;
    end else begin
      capCnt_q <= capCnt_q + 12'h001;
    end
  end

  // playback timer, also the PWM period phase
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      playCnt_q <= '0;
    end else if (playTick) begin
      playCnt_q <= '0;
    end else begin
      playCnt_q <= playCnt_q + 12'h001;
    end
  end

  // request pulses to the DSP, one cycle each
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      captureIrq <= 1'b0;
      playbackIrq <= 1'b0;
      adDoneIrq <= 1'b0;
    end else begin
      captureIrq <= capTick;
      playbackIrq <= playTick;
      adDoneIrq <= convFinish;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      lowestDspIrqLine <= 1'b0;
    end else begin
      lowestDspIrqLine <= ctrl_q.irqSel ? externalPortPin : playTick;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      gpOutputA <= 1'b0;
      gpOutputB <= 1'b0;
      adcPowerOn <= 1'b0;
    end else if (ctrlWr) begin
      gpOutputA <= extReq.wdata[`SCC_B_GPA];
      gpOutputB <= extReq.wdata[`SCC_B_GPB];
      adcPowerOn <= extReq.wdata[`SCC_B_ADCEN];
    end
  end

  assign convFinish = (convState_q == scc_pkg::SCC_CONV) && ctrl_q.adcEn &&
      (convCnt_q == `SCC_CONV_CYC - 6'h01);

  // launch by command or by capture timeout in timer mode
  // a start during a conversion restarts it
  // disabling the converter abandons a conversion
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      convState_q <= scc_pkg::SCC_IDLE;
      convCnt_q <= '0;
    end else if (ctrlWr && !extReq.wdata[`SCC_B_ADCEN]) begin
      convState_q <= scc_pkg::SCC_IDLE;
      convCnt_q <= '0;
    end else if (startCmd || (capTick && !ctrl_q.startBit && ctrl_q.adcEn)) begin
      convState_q <= scc_pkg::SCC_CONV;
      convCnt_q <= '0;
    end else begin
      case (convState_q)
        scc_pkg::SCC_IDLE: begin
          convCnt_q <= '0;
        end
        scc_pkg::SCC_CONV: begin
          if (!ctrl_q.adcEn || convFinish) begin
            convState_q <= scc_pkg::SCC_IDLE;
          end
          convCnt_q <= convCnt_q + 6'h01;
        end
        default: begin
          convState_q <= scc_pkg::SCC_IDLE;
        end
      endcase
    end
  end

  // Busy flag lags the conversion state by one cycle, but drops together with it at a finish
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      adcConvBusy <= 1'b0;
    end else begin
      adcConvBusy <= (convState_q == scc_pkg::SCC_CONV) && !convFinish;
    end
  end

  // done flag; a finish in the read cycle wins over the clear
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      doneFlag_q <= 1'b0;
    end else if (convFinish) begin
      doneFlag_q <= 1'b1;
    end else if (dataRd) begin
      doneFlag_q <= 1'b0;
    end
  end

  // Result captured at the end of conversion
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      adcResult_q <= '0;
    end else if (convFinish) begin
      adcResult_q <= adcSample;
    end
  end

  // result in bits 2-9; fixed reserved reads
  // Unmapped slots read as zero
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      extRdData <= '0;
      extRdValid <= 1'b0;
    end else begin
      extRdValid <= extReq.rd;
      if (!extReq.rd) begin
        extRdData <= extRdData;
      end else if (extReq.addr == `SCC_ADDR_CTRL) begin
        extRdData <= {ctrl_q.irqSel, 5'h00, 1'b1, ctrl_q.playRate, ctrl_q.gpB, ctrl_q.gpA,
            ctrl_q.adcEn, doneFlag_q, ctrl_q.startBit, 1'b0, ctrl_q.xtalSel, ctrl_q.capRate};
      end else if (extReq.addr == `SCC_ADDR_DATA) begin
        extRdData <= {6'h00, adcResult_q, 2'b00};
      end else begin
        extRdData <= '0;
      end
    end
  end

  // ten-bit playback samples queue here; a write while full is dropped
  scc_buffer #(
    .WIDTH(10),
    .DEPTH(2)
  ) uSampleBuf (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .inValid(dataWr),
    .inReady(bufInReady),
    .inData(extReq.wdata[9:0]),
    .outValid(bufOutValid),
    .outReady(playTick),
    .outData(bufOutData)
  );

  // Back-pressure flag for the DSP; it must not write while this is low
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      dacWriteReady <= 1'b0;
    end else begin
      dacWriteReady <= bufInReady && !dataWr;
    end
  end

  // New sample each period; an empty buffer repeats the last one
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pwmSample_q <= '0;
    end else if (playTick && bufOutValid) begin
      pwmSample_q <= bufOutData;
    end
  end

  // four fifths of the period is active
  // whole period at the 10 kHz setting
  assign activeMul = {1'b0, playPeriod, 2'b00} / 15'h0005;
  assign activeLen = (ctrl_q.playRate && !ctrl_q.xtalSel) ? playPeriod : activeMul[11:0];
  assign inActive = (playCnt_q < activeLen);
  assign accSum = {1'b0, acc_q} + `SCC_PWM_SLOTS;

  // spread 1024 slots evenly over the active cycles
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      acc_q <= '0;
      slot_q <= '0;
    end else if (playTick) begin
      acc_q <= '0;
      slot_q <= '0;
    end else if (inActive && (accSum >= {1'b0, activeLen})) begin
      acc_q <= 12'(accSum - {1'b0, activeLen});
      slot_q <= slot_q + 10'h001;
    end else if (inActive) begin
      acc_q <= accSum[11:0];
    end
  end

  // coarse is the upper five bits, fine the lower five
  // slot zero of each group carries fine
  // fine groups high at slot zero, coarse slots in each group
  assign slotHigh = (slot_q[4:0] == 5'h00) ? (slot_q[9:5] < pwmSample_q[4:0]) :
      (slot_q[4:0] <= pwmSample_q[9:5]);

  // output forced low outside the active region
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pwmOut <= 1'b0;
    end else begin
      pwmOut <= inActive && slotHigh;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  gp_out_a_a: assert property (ctrlWr |=> gpOutputA == $past(extReq.wdata[6]))
    else $error("first general output not following bit 6");
  gp_out_b_a: assert property (ctrlWr |=> gpOutputB == $past(extReq.wdata[7]))
    else $error("second general output not following bit 7");
  adc_enable_a: assert property (ctrlWr |=> adcPowerOn == $past(extReq.wdata[5]))
    else $error("power output disagrees with enable bit");
  done_clear_a: assert property (dataRd && !convFinish |=> !doneFlag_q)
    else $error("done flag not cleared by data read");
  start_launch_a: assert property ((startCmd && extReq.wdata[5]) |=> ##1 adcConvBusy)
    else $error("start command did not launch a conversion");
  conv_time_a: assert property (disable iff (!nrst || startCmd ||
      (ctrlWr && !extReq.wdata[5]) || (capTick && !ctrl_q.startBit && ctrl_q.adcEn))
      $rose(adcConvBusy) |-> ##[48:50] adDoneIrq)
    else $error("conversion did not finish in its time");
  reserved_read_a: assert property ((extReq.rd && extReq.addr == 3'h6) |=>
      extRdData[14:10] == 5'h00 && extRdData[9] && !extRdData[2])
    else $error("reserved control bits read wrong");
  pwm_idle_a: assert property (!inActive |=> !pwmOut)
    else $error("PWM high outside active region");
  low_irq_a: assert property (##1 lowestDspIrqLine ==
      ($past(ctrl_q.irqSel) ? $past(externalPortPin) : playbackIrq))
    else $error("lowest interrupt line wrong source");
  cap_pulse_a: assert property (captureIrq |=> (!captureIrq)[*8])
    else $error("capture request not a single pulse per period");

  conv_done_c: cover property (adDoneIrq);
  abort_c: cover property (adcConvBusy && startCmd);
  buf_full_c: cover property (!bufInReady);
  pwm_high_c: cover property ($rose(pwmOut));

endmodule : scc_top

// ---- tb/scc_dsp_model.sv ----
// DSP core model: the only master of the external register port.
// Assumes one access at a time and a register answer one edge after rd.
module scc_dsp_model (
  input wire logic clk_sys,
  output scc_pkg::sccExtReq_t extReq,
  input wire logic [15:0] extRdData,
  input wire logic extRdValid
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    extReq = '0;
  end

  task automatic writeReg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #1 extReq.addr = a;
    extReq.wdata = d;
    extReq.wr = 1'b1;
    @(posedge clk_sys);
    // Released data shows the inverse so a stale value cannot pass
    #1 extReq.wr = 1'b0;
    extReq.wdata = ~d;
  endtask : writeReg

  task automatic readReg(input logic [2:0] a, output logic [15:0] d, output logic v);
    @(posedge clk_sys);
    #1 extReq.addr = a;
    extReq.rd = 1'b1;
    @(posedge clk_sys);
    #1 extReq.rd = 1'b0;
    v = extRdValid;
    d = extRdData;
  endtask : readReg
endmodule : scc_dsp_model

// ---- tb/testbench.sv ----
// Self-checking bench for the converter control block.
// Assumes the DSP model is the only master on the register port.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [15:0] w; logic [15:0] r; logic [2:0] pins;} sccRow_t;
  logic clk_sys, nrst, externalPortPin, ok;
  logic [7:0] adcSample;
  logic [15:0] rdv;
  scc_pkg::sccExtReq_t extReq;
  logic [15:0] extRdData;
  logic extRdValid, gpOutputA, gpOutputB, adcPowerOn, adcConvBusy, captureIrq;
  logic adDoneIrq, playbackIrq, lowestDspIrqLine, pwmOut, dacWriteReady;
  int fail_count = 0;
  int samples_checked = 0;
  int n, h;
  // Write, readback and pin levels {gpB, gpA, enable}
  sccRow_t rows [5] = '{'{16'h0000, 16'h0200, 3'h0}, '{16'hffd7, 16'h83c3, 3'h6},
    '{16'h0040, 16'h0240, 3'h2}, '{16'h0088, 16'h0288, 3'h4},
    '{16'h8103, 16'h8303, 3'h0}};
  // Control words with start set and enable clear, and the periods they give
  logic [15:0] tw [4] = '{16'h0008, 16'h0109, 16'h000a, 16'h010b};
  int capP [4] = '{3125, 1562, 2604, 1562};
  int plyP [4] = '{1562, 2500, 3109, 2604};

  scc_top scc_top_i (.clk_sys(clk_sys), .nrst(nrst), .extReq(extReq),
    .extRdData(extRdData), .extRdValid(extRdValid), .adcSample(adcSample),
    .externalPortPin(externalPortPin), .gpOutputA(gpOutputA), .gpOutputB(gpOutputB),
    .adcPowerOn(adcPowerOn), .adcConvBusy(adcConvBusy), .captureIrq(captureIrq),
    .adDoneIrq(adDoneIrq), .playbackIrq(playbackIrq),
    .lowestDspIrqLine(lowestDspIrqLine), .pwmOut(pwmOut), .dacWriteReady(dacWriteReady));
  scc_dsp_model scc_dsp_model_i (.clk_sys(clk_sys), .extReq(extReq),
    .extRdData(extRdData), .extRdValid(extRdValid));

  // Free-running 25 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    scc_dsp_model_i.writeReg(a, d);
  endtask : wr

  task automatic rdChk(input logic [2:0] a, input logic [15:0] e);
    scc_dsp_model_i.readReg(a, rdv, ok);
    chk("extRdValid", 16'h0001, 16'(ok));
    chk("extRdData", e, rdv);
  endtask : rdChk

  // Bounded wait for a pulse: 0 capture, 1 playback, 2 conversion done
  task automatic waitFor(input int sel, output int cnt);
    logic [2:0] p;
    cnt = 0;
    do begin
      @(posedge clk_sys);
      #1 cnt++;
      p = {adDoneIrq, playbackIrq, captureIrq};
    end while (p[sel] !== 1'b1 && cnt < 5000);
  endtask : waitFor

  // High cycles of the PWM output over one playback period
  task automatic countHigh(output int hc);
    waitFor(1, n);
    hc = 0;
    do begin
      @(posedge clk_sys);
      #1 hc += (pwmOut === 1'b1);
    end while (playbackIrq !== 1'b1 && hc < 5000);
  endtask : countHigh

  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  // Watchdog sized well past the expected run length
  initial begin
    #(80000 * 40);
    fail_count++;
    test_done();
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    externalPortPin = 1'b0;
    adcSample = 8'ha5;
    repeat (6) @(posedge clk_sys);
    #1 nrst = 1'b1;
    chk("outputs after reset", 16'h0000, 16'({gpOutputA, gpOutputB, adcPowerOn, adcConvBusy}));
    rdChk(6, 16'h0208);
    chk("dacWriteReady", 16'h0001, 16'(dacWriteReady));
    $display("reset test done");
    foreach (rows[i]) begin
      wr(6, rows[i].w);
      rdChk(6, rows[i].r);
      chk("gp and enable pins", 16'(rows[i].pins), 16'({gpOutputB, gpOutputA, adcPowerOn}));
    end
    $display("control word test done");
    wr(6, 16'h0028);
    repeat (10) @(posedge clk_sys);
    #1 chk("adcConvBusy", 16'h0001, 16'(adcConvBusy));
    waitFor(2, n);
    chk("conversion cycles", 16'h0028, 16'(n));
    rdChk(6, 16'h0238);
    wr(6, 16'h0000);
    rdChk(6, 16'h0210);
    rdChk(5, 16'h0294);
    rdChk(6, 16'h0200);
    wr(6, 16'h0028);
    repeat (20) @(posedge clk_sys);
    wr(6, 16'h0028);
    waitFor(2, n);
    chk("restart cycles", 16'h0032, 16'(n));
    wr(6, 16'h0028);
    wr(6, 16'h0000);
    repeat (3) @(posedge clk_sys);
    #1 chk("busy after disable", 16'h0000, 16'(adcConvBusy));
    $display("conversion test done");
    foreach (tw[i]) begin
      wr(6, tw[i]);
      waitFor(0, n);
      waitFor(0, n);
      chk("capture period", 16'(capP[i]), 16'(n));
      waitFor(1, n);
      waitFor(1, n);
      chk("playback period", 16'(plyP[i]), 16'(n));
    end
    $display("timer test done");
    // port pin routed to the lowest line
    wr(6, 16'h8000);
    externalPortPin = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 chk("lowestDspIrqLine", 16'h0001, 16'(lowestDspIrqLine));
    externalPortPin = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 chk("lowestDspIrqLine", 16'h0000, 16'(lowestDspIrqLine));
    $display("interrupt select test done");
    // PWM high counts, buffer full drops a word
    wr(6, 16'h0000);
    wr(5, 16'h0000);
    waitFor(1, n);
    chk("lowestDspIrqLine timer", 16'h0001, 16'(lowestDspIrqLine));
    countHigh(h);
    chk("pwm zero sample", 16'h0000, 16'(h));
    wr(5, 16'h03ff);
    wr(5, 16'h03ff);
    chk("dacWriteReady full", 16'h0000, 16'(dacWriteReady));
    wr(5, 16'h0155);
    countHigh(h);
    chk("pwm full sample in region", 16'h0001, 16'(h >= 1240 && h <= 1249));
    chk("dacWriteReady drained", 16'h0001, 16'(dacWriteReady));
    wr(6, 16'h0100);
    waitFor(1, n);
    countHigh(h);
    chk("pwm ten kHz count", 16'h0001, 16'(h >= 2480 && h <= 2500));
    $display("pwm test done");
    test_done();
  end
endmodule : testbench
